// file: logic/rtck_core.sv
// Purpose: Timekeeping core with serial register access
// Assumes: Serial clock and crystal are sampled by the system clock
// Notes:   Serial mode 0 only; addresses wrap within 0x0 to 0xf
`timescale 1ns/10ps
module rtck_core
    import rtck_pkg::*;
#(
    parameter int unsigned XTAL_DIV       = XTAL_HZ,
    parameter int unsigned OSC_CHK_CYCLES = OSC_CHK_CYC
) (
    // System
    input  wire logic I_CLK_SYS,
    input  wire logic I_RST_N,
    // Serial register port
    input  wire logic I_SPI_CS_N,
    input  wire logic I_SPI_SCK,
    input  wire logic I_SPI_SI,
    output logic      O_SPI_SO,
    output logic      O_SPI_SO_OE_N,
    // Crystal oscillator
    input  wire logic I_XTAL,
    output logic      O_OSC_EN
);
    localparam int PRE_W = $clog2(XTAL_DIV);
    localparam int CHK_W = $clog2(OSC_CHK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(XTAL_DIV - 1);
    localparam logic [CHK_W-1:0] CHK_LAST = CHK_W'(OSC_CHK_CYCLES - 1);

    // BCD step: {carry, next}; bad nibbles run on to f
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
        input logic [7:0] mx, input logic [7:0] mn);
        logic [8:0] r;
        r = {1'b0, v};
        if (v == mx) begin
            r = {1'b1, mn};
        end else if (v[3:0] == 4'h9 || v[3:0] == 4'hf) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    // BCD value divisible by four
    function automatic logic div4(input logic [7:0] v);
        logic d;
        d = v[4] ? (v[3:0] == 4'h2 || v[3:0] == 4'h6)
                 : (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
        return d;
    endfunction : div4

    // Last date of the month
    function automatic logic [7:0] last_day(input rtck_time_s t);
        logic [7:0] d;
        logic       leap;
        leap = (t.yr == B_ZERO) ? div4(t.cen) : div4(t.yr);
        case (t.mon)
            B_FEB:   d = leap ? B_29 : B_28;
            B_APR,
            B_JUN,
            B_SEP,
            B_NOV:   d = B_30;
            default: d = B_31;
        endcase
        return d;
    endfunction : last_day

    // Writable bits per address
    function automatic logic [7:0] wmask(input logic [3:0] a);
        logic [7:0] m;
        case (a)
            A_SEC:   m = M_SEC;
            A_MIN:   m = M_MIN;
            A_HOUR:  m = M_HOUR;
            A_WDAY:  m = M_WDAY;
            A_DATE:  m = M_DATE;
            A_MON:   m = M_MON;
            A_CAL:   m = M_CAL;
            default: m = M_ALL;
        endcase
        return m;
    endfunction : wmask

    logic [3:0]       sync1_q;
    logic [3:0]       sync2_q;
    logic             sck_d_q;
    logic             xtal_d_q;
    rtck_spi_e        spi_st_q;
    logic [2:0]       bit_q;
    logic [7:0]       shift_q;
    logic [3:0]       addr_q;
    logic             rd_mode_q;
    logic [7:0]       tx_q;
    logic             wr_stb_q;
    logic [3:0]       wr_addr_q;
    logic [7:0]       wr_data_q;
    rtck_time_s       cnt_q;
    rtck_time_s       cnt_d;
    rtck_time_s       usr_q;
    rtck_time_s       base_q;
    logic [7:0]       aux_q [0:7];
    logic [7:0]       cal_q;
    logic             rd_bit_q;
    logic             wr_bit_q;
    logic             fail_flag_q;
    logic             xfer_q;
    logic [PRE_W-1:0] pre_q;
    logic             tick_q;
    logic [CHK_W-1:0] chk_q;
    logic             chk_done_q;
    logic             seen_q;
    logic             fail_q;
    logic             cs_act;
    logic             sck_rise;
    logic             sck_fall;
    logic             xtal_rise;
    logic             osc_dis;
    logic [7:0]       rx_byte;
    logic [3:0]       rd_a;
    logic [7:0]       rd_d;
    logic [7:0]       wd;

    // Two-stage sync of {cs_n, sck, si, xtal}; pins are asynchronous
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            // Idle pin levels, so no false edge follows reset
            sync1_q  <= 4'h8;
            sync2_q  <= 4'h8;
            sck_d_q  <= 1'b0;
            xtal_d_q <= 1'b0;
        end else begin
            sync1_q  <= {I_SPI_CS_N, I_SPI_SCK, I_SPI_SI, I_XTAL};
            sync2_q  <= sync1_q;
            sck_d_q  <= sync2_q[2];
            xtal_d_q <= sync2_q[0];
        end
    end

    // Edge detection on synchronised pins
    assign cs_act    = ~sync2_q[3];
    assign sck_rise  = sync2_q[2] & ~sck_d_q;
    assign sck_fall  = ~sync2_q[2] & sck_d_q;
    assign xtal_rise = sync2_q[0] & ~xtal_d_q;
    assign rx_byte   = {shift_q[6:0], sync2_q[1]};
    assign osc_dis   = cal_q[C_OSC_DIS];
    assign wd        = wr_data_q & wmask(wr_addr_q);

    // Register read mux; next byte is fetched ahead of the shift
    assign rd_a = (spi_st_q == SP_ADDR) ? rx_byte[3:0] : addr_q + 4'h1;
    always_comb begin
        case (rd_a)
            A_FLAGS: rd_d = 8'h00 | ({7'h00, rd_bit_q} << F_READ)
                        | ({7'h00, wr_bit_q} << F_WRITE)
                        | ({7'h00, fail_flag_q} << F_OSC_FAIL);
            A_CAL:   rd_d = cal_q;
            A_CEN:   rd_d = usr_q.cen;
            A_SEC:   rd_d = usr_q.sec;
            A_MIN:   rd_d = usr_q.min;
            A_HOUR:  rd_d = usr_q.hr;
            A_WDAY:  rd_d = usr_q.wday;
            A_DATE:  rd_d = usr_q.date;
            A_MON:   rd_d = usr_q.mon;
            A_YEAR:  rd_d = usr_q.yr;
            default: rd_d = aux_q[rd_a[2:0]];
        endcase
    end

    // Serial frame: opcode, address, then a burst of data bytes
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            spi_st_q  <= SP_CMD;
            bit_q     <= 3'h0;
            shift_q   <= 8'h00;
            addr_q    <= 4'h0;
            rd_mode_q <= 1'b0;
            tx_q      <= 8'h00;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 4'h0;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (!cs_act) begin
                spi_st_q <= SP_CMD;
                bit_q    <= 3'h0;
            end else if (sck_rise) begin
                bit_q   <= bit_q + 3'h1;
                shift_q <= rx_byte;
                if (bit_q == 3'h7) begin
                    case (spi_st_q)
                        SP_CMD: begin
                            rd_mode_q <= (rx_byte == OP_REG_RD);
                            spi_st_q  <= (rx_byte == OP_REG_RD ||
                                rx_byte == OP_REG_WR) ? SP_ADDR : SP_IGN;
                        end
                        SP_ADDR: begin
                            addr_q   <= rx_byte[3:0];
                            tx_q     <= rd_d;
                            // Outside 0x0 to 0xf the frame is dropped
                            spi_st_q <= (rx_byte > {4'h0, A_MAX})
                                ? SP_IGN : SP_DATA;
                        end
                        SP_DATA: begin
                            addr_q <= addr_q + 4'h1;
                            if (rd_mode_q) begin
                                tx_q <= rd_d;
                            end else begin
                                wr_stb_q  <= 1'b1;
                                wr_addr_q <= addr_q;
                                wr_data_q <= rx_byte;
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (sck_fall && bit_q != 3'h0) begin
                // The fall right after a load keeps the new MSB on the pin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Serial output, driven only in the read data phase
    assign O_SPI_SO      = tx_q[7];
    assign O_SPI_SO_OE_N = ~(cs_act & rd_mode_q & (spi_st_q == SP_DATA));

    // Flags: read and write bits always writable, the rest gated
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rd_bit_q    <= 1'b0;
            wr_bit_q    <= 1'b0;
            fail_flag_q <= 1'b0;
            xfer_q      <= 1'b0;
        end else begin
            xfer_q <= wr_stb_q && wr_addr_q == A_FLAGS && wr_bit_q
                      && !wr_data_q[F_WRITE];
            if (wr_stb_q && wr_addr_q == A_FLAGS) begin
                rd_bit_q <= wr_data_q[F_READ];
                wr_bit_q <= wr_data_q[F_WRITE];
                if (wr_bit_q) begin
                    fail_flag_q <= wr_data_q[F_OSC_FAIL];
                end
            end
            // A failure in the clearing cycle still wins
            if (fail_q) begin
                fail_flag_q <= 1'b1;
            end
        end
    end

    // Calibration and oscillator disable, loaded under the write bit
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            cal_q <= 8'h00;
        end else if (wr_stb_q && wr_bit_q && wr_addr_q == A_CAL) begin
            cal_q <= wd;
        end
    end
    assign O_OSC_EN = ~osc_dis;

    // User-visible registers: host writes or a copy of the counters
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            usr_q <= '0;
            for (int i = 0; i < 8; i++) begin
                aux_q[i] <= 8'h00;
            end
        end else if (wr_stb_q && wr_bit_q) begin
            case (wr_addr_q)
                A_CEN:   usr_q.cen  <= wd;
                A_SEC:   usr_q.sec  <= wd;
                A_MIN:   usr_q.min  <= wd;
                A_HOUR:  usr_q.hr   <= wd;
                A_WDAY:  usr_q.wday <= wd;
                A_DATE:  usr_q.date <= wd;
                A_MON:   usr_q.mon  <= wd;
                A_YEAR:  usr_q.yr   <= wd;
                A_FLAGS,
                A_CAL:   ;
                default: aux_q[wr_addr_q[2:0]] <= wd;
            endcase
        end else if (!rd_bit_q && !wr_bit_q && !xfer_q) begin
            // Whole struct in one edge, so no torn time
            usr_q <= cnt_q;
        end
    end

    // Base time captured as the written values go live
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            base_q <= '0;
        end else if (xfer_q) begin
            base_q <= usr_q;
        end
    end

    // Crystal prescaler; cleared while stopped so restart takes 1 s
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (osc_dis) begin
                pre_q <= '0;
            end else if (xtal_rise) begin
                if (pre_q == PRE_LAST) begin
                    pre_q  <= '0;
                    tick_q <= 1'b1;
                end else begin
                    pre_q <= pre_q + 1'b1;
                end
            end
        end
    end

    // Power-on check: no crystal edge inside the window means failure unless the oscillator is disabled
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            chk_q      <= '0;
            chk_done_q <= 1'b0;
            seen_q     <= 1'b0;
            fail_q     <= 1'b0;
        end else begin
            fail_q <= 1'b0;
            if (xtal_rise) begin
                seen_q <= 1'b1;
            end
            if (!chk_done_q) begin
                chk_q <= chk_q + 1'b1;
                if (chk_q == CHK_LAST) begin
                    chk_done_q <= 1'b1;
                    fail_q <= !osc_dis && !seen_q
                              && !xtal_rise;
                end
            end
        end
    end

    // One-second cascade over the calendar fields
    always_comb begin
        logic       cy;
        logic [7:0] dmax;
        cy    = 1'b1;
        cnt_d = cnt_q;
        dmax  = last_day(cnt_q);
        {cy, cnt_d.sec} = bcd_inc(cnt_q.sec, B_59, B_ZERO);
        if (cy) begin
            {cy, cnt_d.min} = bcd_inc(cnt_q.min, B_59, B_ZERO);
        end
        if (cy) begin
            {cy, cnt_d.hr} = bcd_inc(cnt_q.hr, B_23, B_ZERO);
        end
        if (cy) begin
            // Weekday carry has no use, so only the digits are kept
            cnt_d.wday = 8'(bcd_inc(cnt_q.wday, B_7, B_ONE));
            {cy, cnt_d.date} = bcd_inc(cnt_q.date, dmax, B_ONE);
        end
        if (cy) begin
            {cy, cnt_d.mon} = bcd_inc(cnt_q.mon, B_12, B_ONE);
        end
        if (cy) begin
            {cy, cnt_d.yr} = bcd_inc(cnt_q.yr, B_99, B_ZERO);
        end
        if (cy) begin
            {cy, cnt_d.cen} = bcd_inc(cnt_q.cen, B_99, B_ZERO);
        end
    end

    // Running counters: failure reload, then transfer, then tick
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            cnt_q <= '0;
        end else if (fail_q) begin
            cnt_q <= base_q;
        end else if (xfer_q) begin
            // Transfer takes one cycle; host stores after it
            cnt_q <= usr_q;
        end else if (tick_q) begin
            cnt_q <= cnt_d;
        end
    end
endmodule : rtck_core

// file: logic/rtck_pkg.sv
// Purpose: Constants and types for the timekeeping core
// Assumes: 50 MHz system clock, 32.768 kHz crystal clock
// Notes:   Register addresses are 4-bit register indices
package rtck_pkg;
    // Clock rates and timing
    localparam int unsigned CLK_HZ     = 50_000_000;
    localparam int unsigned XTAL_HZ    = 32_768;
    localparam int unsigned OSC_CHK_MS = 5;
    localparam int unsigned OSC_CHK_CYC = (CLK_HZ / 1000) * OSC_CHK_MS;

    // Serial opcodes, arbitrary values
    localparam logic [7:0] OP_REG_WR = 8'h11;
    localparam logic [7:0] OP_REG_RD = 8'h12;

    // Register addresses
    localparam logic [3:0] A_FLAGS = 4'h0;
    localparam logic [3:0] A_CEN   = 4'h6;
    localparam logic [3:0] A_CAL   = 4'h8;
    localparam logic [3:0] A_SEC   = 4'h9;
    localparam logic [3:0] A_MIN   = 4'ha;
    localparam logic [3:0] A_HOUR  = 4'hb;
    localparam logic [3:0] A_WDAY  = 4'hc;
    localparam logic [3:0] A_DATE  = 4'hd;
    localparam logic [3:0] A_MON   = 4'he;
    localparam logic [3:0] A_YEAR  = 4'hf;
    localparam logic [3:0] A_MAX   = 4'hf;

    // Flag and calibration bit positions
    localparam int F_READ = 0;
    localparam int F_WRITE = 1;
    localparam int F_OSC_FAIL = 4;
    localparam int C_OSC_DIS = 7;

    // Writable bit masks, reserved bits read zero
    localparam logic [7:0] M_SEC  = 8'h7f;
    localparam logic [7:0] M_MIN  = 8'h7f;
    localparam logic [7:0] M_HOUR = 8'h3f;
    localparam logic [7:0] M_WDAY = 8'h07;
    localparam logic [7:0] M_DATE = 8'h3f;
    localparam logic [7:0] M_MON  = 8'h1f;
    localparam logic [7:0] M_CAL  = 8'hbf;
    localparam logic [7:0] M_ALL  = 8'hff;

    // BCD field limits
    localparam logic [7:0] B_ZERO = 8'h00;
    localparam logic [7:0] B_ONE  = 8'h01;
    localparam logic [7:0] B_59   = 8'h59;
    localparam logic [7:0] B_23   = 8'h23;
    localparam logic [7:0] B_7    = 8'h07;
    localparam logic [7:0] B_12   = 8'h12;
    localparam logic [7:0] B_99   = 8'h99;
    localparam logic [7:0] B_28   = 8'h28;
    localparam logic [7:0] B_29   = 8'h29;
    localparam logic [7:0] B_30   = 8'h30;
    localparam logic [7:0] B_31   = 8'h31;
    localparam logic [7:0] B_FEB  = 8'h02;
    localparam logic [7:0] B_APR  = 8'h04;
    localparam logic [7:0] B_JUN  = 8'h06;
    localparam logic [7:0] B_SEP  = 8'h09;
    localparam logic [7:0] B_NOV  = 8'h11;

    // Time of day and date, BCD
    typedef struct packed {
        logic [7:0] cen;
        logic [7:0] yr;
        logic [7:0] mon;
        logic [7:0] date;
        logic [7:0] wday;
        logic [7:0] hr;
        logic [7:0] min;
        logic [7:0] sec;
    } rtck_time_s;

    // Serial frame phase
    typedef enum logic [1:0] {
        SP_CMD  = 2'b00,
        SP_ADDR = 2'b01,
        SP_DATA = 2'b10,
        SP_IGN  = 2'b11
    } rtck_spi_e;
endpackage : rtck_pkg

// file: test/rtck_host.sv
// Purpose: Serial host model issuing register frames, mode 0
// Assumes: Serial clock of 160 ns made from the 50 MHz clock
// Notes:   Serial clock stands low between frames
`timescale 1ns/10ps
module rtck_host (
    // Clock
    input  wire logic i_clk,
    // Serial lines toward the core
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    input  wire logic i_so,
    input  wire logic i_so_oe_n
);
    localparam int HALF = 4; // Half of the 160 ns serial period
    logic [7:0] txb [16];
    logic [7:0] rxb [16];
    logic       oe_seen;

    // Idle lines at time zero
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        oe_seen = 1'b0;
    end

    // Notes any drive of the data out line inside a frame
    always @(posedge i_clk) begin
        if (!o_cs_n && !i_so_oe_n)
            oe_seen <= 1'b1;
    end

    // Lines move just after a clock edge only
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    // One byte, MSB first; data out taken mid high phase
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_si = tx[i];
            step(HALF);
            o_sck = 1'b1;
            step(2);
            // Released line reads inverted, so a missing drive shows
            rx[i] = i_so_oe_n ? ~i_so : i_so;
            step(HALF - 2);
            o_sck = 1'b0;
        end
    endtask : shift

    // Opcode, address byte, then n data bytes; stores land at least
    // a byte apart, so none can precede the transfer delay
    task automatic frame(input logic [7:0] op, input logic [7:0] a,
                         input int n);
        logic [7:0] junk;
        step(1);
        oe_seen = 1'b0;
        o_cs_n = 1'b0;
        shift(op, junk);
        shift(a, junk);
        for (int k = 0; k < n; k++)
            shift(txb[k], rxb[k]);
        step(HALF);
        o_cs_n = 1'b1;
        o_si = ~o_si; // No stale level left on a released line
        step(4);
    endtask : frame
endmodule : rtck_host

// file: test/rtck_props.sv
// Purpose: Port-level checks for the timekeeping core
// Assumes: Serial lines and crystal are sampled by the system clock
// Notes:   Attached to the core by the bind at the foot of this file
`timescale 1ns/10ps
module rtck_props
    import rtck_pkg::*;
#(
    parameter int unsigned XTAL_DIV       = XTAL_HZ,
    parameter int unsigned OSC_CHK_CYCLES = OSC_CHK_CYC
) (
    // System
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Serial register port
    input wire logic I_SPI_CS_N,
    input wire logic I_SPI_SCK,
    input wire logic I_SPI_SI,
    input wire logic O_SPI_SO,
    input wire logic O_SPI_SO_OE_N,
    // Crystal oscillator
    input wire logic I_XTAL,
    input wire logic O_OSC_EN
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);

    // Deselected long enough for the sync pipe to settle
    sequence s_idle;
        I_SPI_CS_N [*4];
    endsequence
    // Deselected long enough that no write can still land
    sequence s_long_idle;
        I_SPI_CS_N [*8];
    endsequence
    // Frame start; data out must stay released for 8 cycles, starting with the cycle of the fall
    sequence s_frame_start;
        $fell(I_SPI_CS_N);
    endsequence

    a_reset_outputs: assert property ($rose(I_RST_N) |->
        O_SPI_SO_OE_N && O_OSC_EN && !O_SPI_SO)
        else $error("outputs not at reset values");
    a_idle_no_drive: assert property (s_idle |->
        O_SPI_SO_OE_N)
        else $error("data out driven while deselected");
    a_release_drive: assert property ($rose(I_SPI_CS_N) |->
        ##[1:4] O_SPI_SO_OE_N)
        else $error("data out not released after deselect");
    a_quiet_start: assert property (s_frame_start |->
        O_SPI_SO_OE_N [*8])
        else $error("data out driven before address");
    a_drive_in_frame: assert property ($fell(O_SPI_SO_OE_N) |->
        !$past(I_SPI_CS_N, 3))
        else $error("drive began without a selected frame");
    a_drive_holds: assert property (!O_SPI_SO_OE_N &&
        !I_SPI_CS_N && !$past(I_SPI_CS_N) |=> !O_SPI_SO_OE_N)
        else $error("drive dropped inside a read frame");
    a_osc_by_write: assert property ($changed(O_OSC_EN) |->
        !$past(I_SPI_CS_N, 4))
        else $error("oscillator enable moved without a write");
    a_osc_steady: assert property (s_long_idle |->
        $stable(O_OSC_EN))
        else $error("oscillator enable moved while idle");
endmodule : rtck_props

bind rtck_core rtck_props #(
    .XTAL_DIV       (XTAL_DIV),
    .OSC_CHK_CYCLES (OSC_CHK_CYCLES)
) i_rtck_props (
    .I_CLK_SYS     (I_CLK_SYS),
    .I_RST_N       (I_RST_N),
    .I_SPI_CS_N    (I_SPI_CS_N),
    .I_SPI_SCK     (I_SPI_SCK),
    .I_SPI_SI      (I_SPI_SI),
    .O_SPI_SO      (O_SPI_SO),
    .O_SPI_SO_OE_N (O_SPI_SO_OE_N),
    .I_XTAL        (I_XTAL),
    .O_OSC_EN      (O_OSC_EN)
);

// file: test/testbench.sv
// Purpose: Self-checking bench for the timekeeping core
// Assumes: Crystal held by the bench so seconds advance on demand
// Notes:   Short prescaler and oscillator check window
`timescale 1ns/10ps
`define CHK(a, e) begin \
    total_checks++; \
    if ((a) !== (e)) begin \
        failures++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
    end \
end
module testbench
    import rtck_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, xtal, cs_n, sck, si, so, so_oe_n, osc_en;
    int   failures = 0;
    int   total_checks = 0;
    rtck_time_s corner [4] = '{64'h2099_1231_0723_5959,
        64'h2000_0228_0323_5959, 64'h2101_0228_0323_5959,
        64'h2024_0615_0210_203a};
    int   cn [4] = '{1, 1, 1, 7};

    // 50 MHz system clock
    always #10 clk = ~clk;

    rtck_core #(.XTAL_DIV(4), .OSC_CHK_CYCLES(50)) i_rtck_core (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SPI_CS_N(cs_n),
        .I_SPI_SCK(sck), .I_SPI_SI(si), .O_SPI_SO(so),
        .O_SPI_SO_OE_N(so_oe_n), .I_XTAL(xtal), .O_OSC_EN(osc_en));
    rtck_host i_rtck_host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck),
        .o_si(si), .i_so(so), .i_so_oe_n(so_oe_n));

    // Nibble past 9 keeps counting up to f before it wraps
    function automatic logic [7:0] bi(input logic [7:0] v);
        if (v[3:0] == 4'h9 || v[3:0] == 4'hf)
            return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction : bi

    function automatic logic [7:0] tobcd(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction : tobcd

    // Expected time one second later, calendar and leap years
    function automatic rtck_time_s nxt(input rtck_time_s t);
        logic [7:0] y, dm;
        t.sec = (t.sec == B_59) ? B_ZERO : bi(t.sec);
        if (t.sec != B_ZERO) return t;
        t.min = (t.min == B_59) ? B_ZERO : bi(t.min);
        if (t.min != B_ZERO) return t;
        t.hr = (t.hr == B_23) ? B_ZERO : bi(t.hr);
        if (t.hr != B_ZERO) return t;
        t.wday = (t.wday == B_7) ? B_ONE : bi(t.wday);
        y = (t.yr == B_ZERO) ? t.cen : t.yr;
        dm = B_31;
        if (t.mon == B_FEB)
            dm = ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? B_29 : B_28;
        else if (t.mon inside {B_APR, B_JUN, B_SEP, B_NOV})
            dm = B_30;
        t.date = (t.date == dm) ? B_ONE : bi(t.date);
        if (t.date != B_ONE) return t;
        t.mon = (t.mon == B_12) ? B_ONE : bi(t.mon);
        if (t.mon != B_ONE) return t;
        t.yr = (t.yr == B_99) ? B_ZERO : bi(t.yr);
        if (t.yr != B_ZERO) return t;
        t.cen = bi(t.cen);
        return t;
    endfunction : nxt

    // Bytes at 0x06 to 0x0f in address order
    function automatic logic [79:0] pack(input rtck_time_s t,
                                         input logic [7:0] sp);
        return {t.cen, sp, 8'h00, t.sec, t.min, t.hr, t.wday, t.date,
                t.mon, t.yr};
    endfunction : pack

    task automatic wr1(input logic [3:0] a, input logic [7:0] d);
        i_rtck_host.txb[0] = d;
        i_rtck_host.frame(OP_REG_WR, {4'h0, a}, 1);
    endtask : wr1

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        i_rtck_host.frame(OP_REG_RD, {4'h0, a}, 1);
        `CHK(i_rtck_host.rxb[0], e)
    endtask : rd_chk

    // Crystal runs only here, four rises per second
    task automatic tick(input int n);
        repeat (n * 4) begin
            repeat (13) @(posedge clk);
            #1 xtal = 1'b1;
            repeat (13) @(posedge clk);
            #1 xtal = 1'b0;
        end
    endtask : tick

    task automatic cmp_time(input rtck_time_s e, input logic [7:0] sp);
        logic [79:0] pk;
        pk = pack(e, sp);
        i_rtck_host.frame(OP_REG_RD, 8'h06, 10);
        for (int k = 0; k < 10; k++)
            `CHK(i_rtck_host.rxb[k], pk[79 - 8 * k -: 8])
    endtask : cmp_time

    // Stop the oscillator while loading, so the count starts clean
    task automatic set_time(input rtck_time_s t, input logic [7:0] sp);
        logic [79:0] pk;
        pk = pack(t, sp);
        wr1(A_FLAGS, 8'h02);
        wr1(A_CAL, 8'h80);
        `CHK(osc_en, 1'b0)
        for (int k = 0; k < 10; k++)
            i_rtck_host.txb[k] = pk[79 - 8 * k -: 8];
        i_rtck_host.txb[2] = 8'h40; // Bit 6 must read back zero
        i_rtck_host.frame(OP_REG_WR, 8'h06, 10);
        `CHK(osc_en, 1'b1)
        wr1(A_FLAGS, 8'h00);
    endtask : set_time

    task automatic run_case(input rtck_time_s t, input int n);
        logic [7:0] sp;
        rtck_time_s e;
        sp = 8'($urandom);
        e = t;
        set_time(t, sp);
        tick(n);
        repeat (n) e = nxt(e);
        wr1(A_FLAGS, 8'h01);
        tick(2);
        wr1(A_SEC, 8'h55); // Refused with the write bit clear
        cmp_time(e, sp);
        rd_chk(A_FLAGS, 8'h01);
        wr1(A_FLAGS, 8'h00);
        repeat (4) @(posedge clk);
        wr1(A_FLAGS, 8'h01);
        e = nxt(nxt(e));
        cmp_time(e, sp);
        wr1(A_FLAGS, 8'h00);
    endtask : run_case

    task automatic end_sim();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        rtck_time_s t;
        rst_n = 1'b0;
        xtal = 1'b0;
        void'($urandom(65));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (60) @(posedge clk); // Crystal still: check window lapses
        rd_chk(A_FLAGS, 8'h10);
        cmp_time('0, 8'h00);
        wr1(A_FLAGS, 8'h00);
        rd_chk(A_FLAGS, 8'h10);
        wr1(A_FLAGS, 8'h02);
        rd_chk(A_FLAGS, 8'h12);
        wr1(A_FLAGS, 8'h02);
        rd_chk(A_FLAGS, 8'h02);
        wr1(A_FLAGS, 8'h00);
        i_rtck_host.frame(8'h33, 8'h00, 1);
        `CHK(i_rtck_host.oe_seen, 1'b0)
        i_rtck_host.frame(OP_REG_RD, 8'h10, 1);
        `CHK(i_rtck_host.oe_seen, 1'b0)
        for (int k = 0; k < 4; k++)
            run_case(corner[k], cn[k]);
        // Random 24-hour times in valid BCD
        repeat (4) begin
            t = {tobcd($urandom % 100), tobcd($urandom % 100),
                 tobcd(1 + $urandom % 12), tobcd(1 + $urandom % 28),
                 tobcd(1 + $urandom % 7), tobcd($urandom % 24),
                 tobcd($urandom % 60), tobcd($urandom % 60)};
            run_case(t, 1 + $urandom % 4);
        end
        end_sim();
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (95000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule : testbench
